/* File: rtl/ecf_defines.svh */
`ifndef ECF_DEFINES_SVH
`define ECF_DEFINES_SVH
// Register byte offsets
`define ECF_A_CTRL     8'h00
`define ECF_A_CMD      8'h04
`define ECF_A_STATUS   8'h08
`define ECF_A_LSHIFT   8'h0C
`define ECF_A_LSTRETCH 8'h10
`define ECF_A_FSHIFT   8'h14
`define ECF_A_FSTRETCH 8'h18
`define ECF_A_START    8'h1C
`define ECF_A_PERIOD   8'h20
`define ECF_A_VEL      8'h24
`define ECF_A_ACC      8'h28
`define ECF_A_DEC      8'h2C
`define ECF_A_JERK     8'h30
`define ECF_A_PRESET   8'h34
`define ECF_A_TIDX     8'h38
`define ECF_A_TDATA    8'h3C
`define ECF_A_LEADPOS  8'h40
`define ECF_A_FOLPOS   8'h44
// Command bit positions
`define ECF_C_ENGAGE   0
`define ECF_C_RELEASE  1
`define ECF_C_HALT     2
`define ECF_C_PAUSE    3
`define ECF_C_HOME_F   4
`define ECF_C_HOME_L   5
`define ECF_C_PRE_L    6
`define ECF_C_PRE_F    7
`define ECF_C_CLRERR   8
// Control field positions
`define ECF_F_REPEAT   0
`define ECF_F_QUEUE    3
// Reset values
`define ECF_R_CTRL     4'h0
`define ECF_R_ONE      32'h0000_0001
`define ECF_R_PERIOD   32'h0000_1000
// Fault codes
`define ECF_E_NONE     8'h00
`define ECF_E_HOME     8'h01
`define ECF_E_STRETCH  8'h02
`define ECF_E_AXIS     8'h03
`endif

/* File: rtl/ecf_pkg.sv */
`default_nettype none
package ecf_pkg;
  typedef enum logic [2:0] {
    ecf_idle, ecf_waiting, ecf_engaging, ecf_synced, ecf_stopping, ecf_faulted
  } ecf_state_type;
  typedef enum logic [1:0] {
    ecf_jump, ecf_ramp_nearest_way, ecf_ramp_upward_way, ecf_ramp_downward_way
  } ecf_style_type;
endpackage : ecf_pkg
`default_nettype wire

/* File: rtl/ecf_core.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ecf_defines.svh"
module ecf_core #(
  parameter int DEPTH = 16,
  parameter int AW    = 4
) (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  // AHB-Lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  // Axes
  input  wire logic        tick_i,
  input  wire logic [31:0] lead_pos_i,
  input  wire logic        axis_fault_i,
  output logic      [31:0] follower_pos_o,
  output logic             lead_preset_o,
  output logic      [31:0] lead_preset_val_o,
  output logic             lead_home_o,
  output logic             profile_end_o,
  output logic             in_sync_o,
  output logic             error_o,
  output logic             busy_o
);
  // ----------------------------------------
  // Parameter check
  // ----------------------------------------
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad
    $error("DEPTH must be a power of two equal to 2**AW");
  end

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic        ap_wr_r;
  logic        ap_rd_r;
  logic [7:0]  ap_addr_r;
  logic        take;
  logic        wr_en;
  logic [31:0] rd_val;
  assign take  = hsel_i && hready_i && htrans_i[1];
  assign wr_en = ap_wr_r;

  // Address phase capture, held while a read waits
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ap_wr_r   <= 1'b0;
      ap_rd_r   <= 1'b0;
      ap_addr_r <= 8'h00;
    end else if (hready_i) begin
      ap_wr_r   <= take && hwrite_i;
      ap_rd_r   <= take && !hwrite_i;
      ap_addr_r <= haddr_i[7:0];
    end
  end

  // One wait state on reads so data is always current
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hreadyout_o <= 1'b1;
      hrdata_o    <= 32'h0000_0000;
      hresp_o     <= 1'b0;
    end else begin
      hreadyout_o <= !(take && !hwrite_i);
      hresp_o     <= 1'b0;
      if (ap_rd_r && !hreadyout_o) begin
        hrdata_o <= rd_val;
      end
    end
  end

  // Command strobes from a write to the command word
  logic [8:0] cmd;
  assign cmd = (wr_en && ap_addr_r == `ECF_A_CMD) ? hwdata_i[8:0] : 9'h000;

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  logic        [3:0]  ctrl_r;
  logic signed [31:0] lead_shift_r, lead_stretch_r, follower_shift_r, fol_stretch_r;
  logic signed [31:0] start_pos_r, period_r, vel_lim_r, acc_lim_r, dec_lim_r, jerk_lim_r;
  logic signed [31:0] preset_val_r;
  logic        [AW-1:0] tidx_r;
  logic signed [31:0] tbl [DEPTH];

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_r           <= `ECF_R_CTRL;
      lead_shift_r     <= 32'h0000_0000;
      lead_stretch_r   <= `ECF_R_ONE;
      follower_shift_r <= 32'h0000_0000;
      fol_stretch_r    <= `ECF_R_ONE;
      start_pos_r      <= 32'h0000_0000;
      period_r         <= `ECF_R_PERIOD;
      vel_lim_r        <= `ECF_R_ONE;
      acc_lim_r        <= `ECF_R_ONE;
      dec_lim_r        <= `ECF_R_ONE;
      jerk_lim_r       <= `ECF_R_ONE;
      preset_val_r     <= 32'h0000_0000;
    end else if (wr_en) begin
      case (ap_addr_r)
        `ECF_A_CTRL:     ctrl_r           <= hwdata_i[3:0];
        `ECF_A_LSHIFT:   lead_shift_r     <= hwdata_i;
        `ECF_A_LSTRETCH: lead_stretch_r   <= hwdata_i;
        `ECF_A_FSHIFT:   follower_shift_r <= hwdata_i;
        `ECF_A_FSTRETCH: fol_stretch_r    <= hwdata_i;
        `ECF_A_START:    start_pos_r      <= hwdata_i;
        `ECF_A_PERIOD:   period_r         <= hwdata_i;
        `ECF_A_VEL:      vel_lim_r        <= hwdata_i;
        `ECF_A_ACC:      acc_lim_r        <= hwdata_i;
        `ECF_A_DEC:      dec_lim_r        <= hwdata_i;
        `ECF_A_JERK:     jerk_lim_r       <= hwdata_i;
        `ECF_A_PRESET:   preset_val_r     <= hwdata_i;
        default: ;
      endcase
    end
  end

  // Cam table, written through index and data words; index steps on each data write
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tidx_r <= '0;
    end else if (wr_en && ap_addr_r == `ECF_A_TIDX) begin
      tidx_r <= hwdata_i[AW-1:0];
    end else if (wr_en && ap_addr_r == `ECF_A_TDATA) begin
      tidx_r <= tidx_r + 1'b1;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (wr_en && ap_addr_r == `ECF_A_TDATA) begin
      tbl[tidx_r] <= hwdata_i;
    end
  end

  // ----------------------------------------
  // Cam evaluation
  // ----------------------------------------
  ecf_pkg::ecf_state_type state_r;
  ecf_pkg::ecf_style_type style;
  logic signed [31:0] lead_ref_r, pos_r, v_r, a_r;
  logic               dir_r, pend_r;
  logic        [7:0]  fault_r;
  logic signed [31:0] rel, ph, cyc, stroke, target;
  logic signed [31:0] up_d, dn_d, rem, v_n, a_n, step;
  logic        [AW-1:0] idx;
  logic               go_up, at_end, flt_now;

  // Non-negative remainder of x by p; x itself when p is not positive
  function automatic logic signed [31:0] pmod(input logic signed [31:0] x, input logic signed [31:0] p);
    logic signed [31:0] r;
    r = (p > 0) ? x % p : x;
    if (r < 0 && p > 0) begin
      r = r + p;
    end
    return r;
  endfunction : pmod

  // Lesser of two values
  function automatic logic signed [31:0] smin(input logic signed [31:0] a, input logic signed [31:0] b);
    return (a < b) ? a : b;
  endfunction : smin

  assign style = ecf_pkg::ecf_style_type'(ctrl_r[2:1]);
  // Lead phase: shift, then divide by stretch, then look up
  assign rel    = lead_pos_i - lead_ref_r + lead_shift_r;
  assign ph     = rel / ((lead_stretch_r == 0) ? $signed(`ECF_R_ONE) : lead_stretch_r);
  assign cyc    = ph >>> AW;
  assign idx    = ph[AW-1:0];
  // Stroke difference accumulates per completed cycle; zero for reciprocating
  assign stroke = tbl[DEPTH-1] - tbl[0];
  // Scale the table output, then add the follower shift
  assign target = 32'(32'(tbl[idx] + 32'(cyc * stroke)) * fol_stretch_r) + follower_shift_r;
  assign at_end = (idx == AW'(DEPTH - 1));
  // Ramp distances both ways within the follower period
  assign up_d   = pmod(target - pos_r, period_r);
  assign dn_d   = pmod(pos_r - target, period_r);
  // Direction choice, ties go upward
  assign go_up  = (style == ecf_pkg::ecf_ramp_upward_way) ||
                  (style == ecf_pkg::ecf_ramp_nearest_way && up_d <= dn_d);
  assign rem    = go_up ? up_d : dn_d;
  // Jerk bounds accel growth, accel bounds speed growth, speed bounded
  assign a_n    = smin(a_r + jerk_lim_r, acc_lim_r);
  assign v_n    = smin(v_r + a_r, vel_lim_r);
  assign step   = smin(v_n, rem);
  assign flt_now = axis_fault_i || cmd[`ECF_C_HOME_F] ||
                   (cmd[`ECF_C_ENGAGE] && lead_stretch_r == 0);

  // Motion state machine; commands and faults act on any clock, motion steps on each tick
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_r       <= ecf_pkg::ecf_idle;
      lead_ref_r    <= 32'h0000_0000;
      pos_r         <= 32'h0000_0000;
      v_r           <= 32'h0000_0000;
      a_r           <= 32'h0000_0000;
      dir_r         <= 1'b1;
      pend_r        <= 1'b0;
      fault_r       <= `ECF_E_NONE;
      profile_end_o <= 1'b0;
    end else begin
      profile_end_o <= 1'b0;
      if (lead_preset_o && (state_r == ecf_pkg::ecf_engaging || state_r == ecf_pkg::ecf_synced)) begin
        lead_ref_r <= lead_ref_r + lead_preset_val_o - lead_pos_i; // Keeps phase across a lead preset
      end
      if (flt_now) begin
        // Fault stops the axis and reports a code
        state_r <= ecf_pkg::ecf_faulted;
        v_r     <= 32'h0000_0000;
        pend_r  <= 1'b0;
        fault_r <= axis_fault_i ? `ECF_E_AXIS : (cmd[`ECF_C_HOME_F] ? `ECF_E_HOME : `ECF_E_STRETCH);
      end else if (state_r == ecf_pkg::ecf_faulted) begin
        if (cmd[`ECF_C_CLRERR]) begin
          state_r <= ecf_pkg::ecf_idle;
          fault_r <= `ECF_E_NONE;
        end
      end else if (cmd[`ECF_C_HALT] || cmd[`ECF_C_PAUSE]) begin
        state_r <= ecf_pkg::ecf_stopping; // Break the cam and decelerate
        pend_r  <= 1'b0;
      end else if (cmd[`ECF_C_RELEASE] && state_r != ecf_pkg::ecf_idle) begin
        state_r <= ecf_pkg::ecf_idle; // Release ends the cam
        v_r     <= 32'h0000_0000;
        pend_r  <= 1'b0;
      end else if (cmd[`ECF_C_ENGAGE]) begin
        // Policy only matters while a motion runs
        if (state_r != ecf_pkg::ecf_idle && ctrl_r[`ECF_F_QUEUE]) begin
          pend_r <= 1'b1;
        end else begin
          state_r <= ecf_pkg::ecf_waiting;
          a_r     <= 32'h0000_0000;
        end
      end else if (tick_i && state_r != ecf_pkg::ecf_idle) begin // Idle ticks leave room for a preset
        case (state_r)
          ecf_pkg::ecf_waiting: begin
            if ($signed(lead_pos_i) >= start_pos_r) begin
              state_r    <= ecf_pkg::ecf_engaging; // Style takes effect from here
              lead_ref_r <= lead_pos_i;
            end
          end
          ecf_pkg::ecf_engaging: begin
            if (style == ecf_pkg::ecf_jump || rem == 0) begin
              pos_r   <= target; // Jump in one cycle
              state_r <= ecf_pkg::ecf_synced;
            end else begin
              pos_r <= go_up ? pos_r + step : pos_r - step;
              dir_r <= go_up;
              v_r   <= v_n;
              a_r   <= a_n;
              if (step == rem) begin
                state_r <= ecf_pkg::ecf_synced;
              end
            end
          end
          ecf_pkg::ecf_synced: begin
            pos_r <= target;
            dir_r <= (target >= pos_r);
            v_r   <= (target >= pos_r) ? target - pos_r : pos_r - target;
            if (at_end) begin
              profile_end_o <= 1'b1;
              if (pend_r) begin
                state_r <= ecf_pkg::ecf_waiting; // Queued command starts on profile end
                pend_r  <= 1'b0;
              end else if (!ctrl_r[`ECF_F_REPEAT]) begin
                state_r <= ecf_pkg::ecf_idle; // Single pass finishes here
              end
            end
            // With repeat on, the index wraps to the first point
          end
          ecf_pkg::ecf_stopping: begin
            pos_r <= dir_r ? pos_r + v_r : pos_r - v_r;
            v_r   <= (v_r > dec_lim_r) ? v_r - dec_lim_r : 32'h0000_0000;
            if (v_r == 0) begin
              state_r <= ecf_pkg::ecf_idle;
            end
          end
          default: ;
        endcase
      end else if (cmd[`ECF_C_PRE_F] && state_r == ecf_pkg::ecf_idle) begin
        pos_r <= preset_val_r; // Follower preset only at standstill
      end
    end
  end

  // Lead preset and reference search requests toward the lead axis
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lead_preset_o     <= 1'b0;
      lead_preset_val_o <= 32'h0000_0000;
      lead_home_o       <= 1'b0;
    end else begin
      lead_preset_o <= cmd[`ECF_C_PRE_L];
      lead_home_o   <= cmd[`ECF_C_HOME_L]; // Search accepted on lead only
      if (cmd[`ECF_C_PRE_L]) begin
        lead_preset_val_o <= preset_val_r;
      end
    end
  end

  // Registered status outputs
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      follower_pos_o <= 32'h0000_0000;
      in_sync_o      <= 1'b0;
      error_o        <= 1'b0;
      busy_o         <= 1'b0;
    end else begin
      follower_pos_o <= pos_r;
      in_sync_o      <= (state_r == ecf_pkg::ecf_synced);
      error_o        <= (state_r == ecf_pkg::ecf_faulted);
      busy_o         <= (state_r != ecf_pkg::ecf_idle) && (state_r != ecf_pkg::ecf_faulted);
    end
  end

  // Read mux; unmapped words read zero
  always_comb begin
    case (ap_addr_r)
      `ECF_A_CTRL:     rd_val = {28'h0000000, ctrl_r};
      `ECF_A_STATUS:   rd_val = {16'h0000, fault_r, 3'h0, pend_r, 1'b0, 3'(state_r)};
      `ECF_A_LSHIFT:   rd_val = lead_shift_r;
      `ECF_A_LSTRETCH: rd_val = lead_stretch_r;
      `ECF_A_FSHIFT:   rd_val = follower_shift_r;
      `ECF_A_FSTRETCH: rd_val = fol_stretch_r;
      `ECF_A_START:    rd_val = start_pos_r;
      `ECF_A_PERIOD:   rd_val = period_r;
      `ECF_A_VEL:      rd_val = vel_lim_r;
      `ECF_A_ACC:      rd_val = acc_lim_r;
      `ECF_A_DEC:      rd_val = dec_lim_r;
      `ECF_A_JERK:     rd_val = jerk_lim_r;
      `ECF_A_PRESET:   rd_val = preset_val_r;
      `ECF_A_TIDX:     rd_val = 32'(tidx_r);
      `ECF_A_LEADPOS:  rd_val = lead_pos_i;
      `ECF_A_FOLPOS:   rd_val = pos_r;
      default:         rd_val = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic hi_cmd;
  assign hi_cmd = flt_now || (|cmd);

  a_jump_sync: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    state_r == ecf_pkg::ecf_engaging && tick_i && !hi_cmd && style == ecf_pkg::ecf_jump
    |=> state_r == ecf_pkg::ecf_synced && pos_r == $past(target))
    else $error("jump engagement did not reach target");
  a_track_curve: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    state_r == ecf_pkg::ecf_synced && tick_i && !hi_cmd |=> pos_r == $past(target) ##1 follower_pos_o == $past(pos_r))
    else $error("follower does not follow the scaled curve");
  a_single_end: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    state_r == ecf_pkg::ecf_synced && tick_i && !hi_cmd && at_end && !pend_r && !ctrl_r[0]
    |=> state_r == ecf_pkg::ecf_idle && profile_end_o)
    else $error("single pass did not finish");
  a_end_pulse: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    profile_end_o |-> $past(tick_i, 1))
    else $error("profile end without a tick");
  a_halt_abort: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    cmd[`ECF_C_HALT] && !flt_now && state_r != ecf_pkg::ecf_faulted
    |=> state_r == ecf_pkg::ecf_stopping && !pend_r)
    else $error("halt did not abort the cam");
  a_home_reject: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    cmd[`ECF_C_HOME_F] && !axis_fault_i |=> fault_r == `ECF_E_HOME ##1 error_o && !lead_home_o)
    else $error("follower search was not refused");
  a_queue_after: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    cmd == 9'h001 && !flt_now && ctrl_r[3] && state_r inside {ecf_pkg::ecf_synced, ecf_pkg::ecf_stopping}
    |=> pend_r && state_r == $past(state_r))
    else $error("queued engage did not wait");
  a_fault_stop: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    axis_fault_i |=> state_r == ecf_pkg::ecf_faulted && v_r == 0 ##1 error_o)
    else $error("fault did not stop the axis");
  a_release_end: assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    cmd == 9'h002 && !axis_fault_i && state_r == ecf_pkg::ecf_synced |=> state_r == ecf_pkg::ecf_idle)
    else $error("release did not end the cam");
  c_synced: cover property (@(posedge core_clk_i) disable iff (!nrst_i) in_sync_o);
  c_wrap: cover property (@(posedge core_clk_i) disable iff (!nrst_i) profile_end_o && ctrl_r[0]);
  c_stop_done: cover property (@(posedge core_clk_i) disable iff (!nrst_i)
    state_r == ecf_pkg::ecf_stopping ##1 state_r == ecf_pkg::ecf_idle);
endmodule : ecf_core
`default_nettype wire

/* File: test/ecf_lead_axis.sv */
`timescale 1ns/1ps
`default_nettype none
module ecf_lead_axis (
  // Clock and reset
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  // Requests from the cam block
  input  wire logic        lead_preset_i,
  input  wire logic [31:0] lead_preset_val_i,
  input  wire logic        lead_home_i,
  // Axis feedback
  output logic             tick_o,
  output logic      [31:0] pos_o
);
  logic [1:0] div_r;
  // Motion cycle pulse on every fourth clock
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) div_r <= 2'h0;
    else div_r <= div_r + 2'h1;
  end
  assign tick_o = (div_r == 2'h3);
  // Lead advances one unit a cycle; a preset or search reloads it at once
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) pos_o <= 32'h0;
    else if (lead_preset_i) pos_o <= lead_preset_val_i;
    else if (lead_home_i) pos_o <= 32'h0;
    else if (tick_o) pos_o <= pos_o + 32'h1;
  end
endmodule : ecf_lead_axis
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ecf_defines.svh"
module tb;
  logic             core_clk_i, nrst_i, hsel_i, hwrite_i, axis_fault_i;
  logic      [1:0]  htrans_i;
  logic      [31:0] haddr_i, hwdata_i, q;
  wire logic [31:0] hrdata_o, follower_pos_o, lead_pos_i, lead_preset_val_o;
  wire logic        hready_i, hreadyout_o, hresp_o, tick_i, lead_preset_o, lead_home_o;
  wire logic        profile_end_o, in_sync_o, error_o, busy_o;
  int               n_mismatch, n_compared, homes;
  // Single slave: its ready is the bus ready
  assign hready_i = hreadyout_o;
  ecf_core dut_u (.core_clk_i, .nrst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i, .hsize_i(3'h2), .hwdata_i,
    .hready_i, .hrdata_o, .hreadyout_o, .hresp_o, .tick_i, .lead_pos_i, .axis_fault_i, .follower_pos_o,
    .lead_preset_o, .lead_preset_val_o, .lead_home_o, .profile_end_o, .in_sync_o, .error_o, .busy_o);
  ecf_lead_axis lead_u (.core_clk_i, .nrst_i, .lead_preset_i(lead_preset_o),
    .lead_preset_val_i(lead_preset_val_o), .lead_home_i(lead_home_o), .tick_o(tick_i), .pos_o(lead_pos_i));
  // Clock
  initial begin
    core_clk_i = 1'b0;
    forever #10 core_clk_i = ~core_clk_i;
  end
  // Watchdog cuts a hang short
  initial begin
    #600000;
    n_mismatch++;
    end_sim();
  end
  // Counts search requests reaching the lead
  always @(posedge core_clk_i) if (lead_home_o === 1'b1) homes++;
  task automatic end_sim();
    $display("Compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One single word transfer; holds each phase until ready is sampled high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    htrans_i <= 2'h0;
    hwdata_i <= d;
    do @(posedge core_clk_i); while (hreadyout_o !== 1'b1);
    q = hrdata_o;
  endtask : bus
  task automatic wait_end();
    int t;
    for (t = 0; t < 600 && profile_end_o !== 1'b1; t++) @(posedge core_clk_i);
    chk("end_seen", 32'(t < 600), 32'h1);
  endtask : wait_end
  task automatic sync_wait();
    int t;
    for (t = 0; t < 300 && in_sync_o !== 1'b1; t++) @(posedge core_clk_i);
    chk("sync_seen", 32'(t < 300), 32'h1);
  endtask : sync_wait
  function automatic logic [31:0] started(input logic [31:0] s);
    return {31'h0, s[4] === 1'b0 && (s[2:0] === 3'h1 || s[2:0] === 3'h2)};
  endfunction : started
  // Configure, bring the lead back to zero, then issue the engage command
  task automatic engage(input logic [31:0] ctrl, lsh, lst, fs, fsh);
    bus(1'b1, `ECF_A_CTRL, ctrl);
    bus(1'b1, `ECF_A_LSHIFT, lsh);
    bus(1'b1, `ECF_A_LSTRETCH, lst);
    bus(1'b1, `ECF_A_FSTRETCH, fs);
    bus(1'b1, `ECF_A_FSHIFT, fsh);
    bus(1'b1, `ECF_A_PRESET, 32'h0);
    bus(1'b1, `ECF_A_CMD, 32'h40);
    bus(1'b1, `ECF_A_CMD, 32'h1);
  endtask : engage
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    logic [31:0] r[6][2] = '{'{`ECF_A_CTRL, 0}, '{`ECF_A_LSTRETCH, `ECF_R_ONE}, '{`ECF_A_FSTRETCH, `ECF_R_ONE},
      '{`ECF_A_PERIOD, `ECF_R_PERIOD}, '{`ECF_A_VEL, `ECF_R_ONE}, '{`ECF_A_STATUS, 0}};
    bus(1'b1, 8'h80, 32'hFFFF_FFFF);
    for (int k = 0; k < 6; k++) begin
      bus(1'b0, r[k][0][7:0], 32'h0);
      chk("reset_val", q, r[k][1]);
    end
    bus(1'b0, 8'h80, 32'h0);
    chk("unmapped", {q[31:1], hresp_o}, 32'h0);
  endtask : t_reset
  // Table holds ten units a point; ramp limits sized for coupling
  task automatic setup();
    bus(1'b1, `ECF_A_TIDX, 32'h0);
    for (int i = 0; i < 16; i++) bus(1'b1, `ECF_A_TDATA, 32'(i * 10));
    bus(1'b1, `ECF_A_START, 32'h5);
    for (int i = 0; i < 4; i++) bus(1'b1, 8'(`ECF_A_VEL + 4 * i), 32'h20);
  endtask : setup
  task automatic t_scale();
    int c[4][4] = '{'{0, 1, 1, 0}, '{0, 1, 2, 7}, '{3, 1, 1, 0}, '{0, 2, 1, 0}};
    for (int k = 0; k < 4; k++) begin
      engage(32'h0, c[k][0], c[k][1], c[k][2], c[k][3]);
      wait_end();
      chk("lead_end", lead_pos_i, 32'(5 + 15 * c[k][1] - c[k][0] + 1));
      repeat (2) @(posedge core_clk_i);
      chk("fol_end", follower_pos_o, 32'(150 * c[k][2] + c[k][3]));
      bus(1'b0, `ECF_A_STATUS, 32'h0);
      chk("idle", q & 32'h7, 32'h0);
    end
  endtask : t_scale
  task automatic t_repeat();
    logic [31:0] l0;
    engage(32'h1, 32'h0, 32'h1, 32'h1, 32'h0);
    wait_end();
    l0 = lead_pos_i;
    repeat (2) @(posedge core_clk_i);
    wait_end();
    chk("lead_cycle", lead_pos_i, l0 + 32'h10);
    repeat (2) @(posedge core_clk_i);
    chk("feed", follower_pos_o, 32'h12C);
    bus(1'b1, `ECF_A_CMD, 32'h2);
    bus(1'b0, `ECF_A_STATUS, 32'h0);
    chk("released", q & 32'h7, 32'h0);
  endtask : t_repeat
  // Style, follower start, required direction of each step
  task automatic t_styles();
    int c[4][3] = '{'{0, 40, 0}, '{1, 40, -1}, '{2, 0, 1}, '{3, 40, -1}};
    int d, bad;
    logic [31:0] prev;
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, `ECF_A_PRESET, 32'(c[k][1]));
      bus(1'b1, `ECF_A_CMD, 32'h80);
      engage(32'(c[k][0] * 2), 32'h0, 32'h1, 32'h1, 32'h0);
      prev = follower_pos_o;
      bad = 0;
      for (int t = 0; t < 300 && in_sync_o !== 1'b1; t++) begin
        @(posedge core_clk_i);
        d = $signed(follower_pos_o - prev);
        if (c[k][2] != 0 && (c[k][2] * d < 0 || d > 32 || d < -32)) bad++;
        prev = follower_pos_o;
      end
      chk("ramp_dir", 32'(bad), 32'h0);
      chk("style_sync", {31'h0, in_sync_o}, 32'h1);
      if (k == 0) chk("jump_at", lead_pos_i, 32'h7);
      bus(1'b1, `ECF_A_CMD, 32'h2);
    end
  endtask : t_styles
  task automatic t_halt();
    for (int k = 2; k < 4; k++) begin
      engage(32'h1, 32'h0, 32'h1, 32'h1, 32'h0);
      sync_wait();
      bus(1'b1, `ECF_A_CMD, 32'(1 << k));
      q = 32'hFFFF_FFFF;
      for (int t = 0; t < 30 && q[2:0] !== 3'h0; t++) bus(1'b0, `ECF_A_STATUS, 32'h0);
      chk("stopped", q & 32'h7, 32'h0);
      chk("unsynced", {30'h0, in_sync_o, busy_o}, 32'h0);
    end
  endtask : t_halt
  task automatic t_fault();
    bus(1'b1, `ECF_A_CMD, 32'h10);
    bus(1'b0, `ECF_A_STATUS, 32'h0);
    chk("fol_search", q & 32'hFF07, 32'h0105);
    chk("err", {31'h0, error_o}, 32'h1);
    bus(1'b1, `ECF_A_CMD, 32'h100);
    bus(1'b1, `ECF_A_CMD, 32'h20);
    bus(1'b0, `ECF_A_STATUS, 32'h0);
    chk("lead_search", {q[15:0], 16'(homes)}, 32'h1);
    axis_fault_i <= 1'b1;
    @(posedge core_clk_i);
    bus(1'b0, `ECF_A_STATUS, 32'h0);
    axis_fault_i <= 1'b0;
    chk("axis_fault", q & 32'hFF07, 32'h0305);
    bus(1'b1, `ECF_A_CMD, 32'h100);
  endtask : t_fault
  task automatic t_queue();
    engage(32'h9, 32'h0, 32'h1, 32'h1, 32'h0);
    sync_wait();
    bus(1'b1, `ECF_A_CMD, 32'h81);
    bus(1'b0, `ECF_A_STATUS, 32'h0);
    chk("queued", q & 32'h17, 32'h13);
    wait_end();
    bus(1'b0, `ECF_A_STATUS, 32'h0);
    chk("follow_on", started(q), 32'h1);
    bus(1'b1, `ECF_A_CTRL, 32'h1);
    sync_wait();
    bus(1'b1, `ECF_A_CMD, 32'h1);
    bus(1'b0, `ECF_A_STATUS, 32'h0);
    chk("aborted", started(q), 32'h1);
    bus(1'b1, `ECF_A_CMD, 32'h2);
    bus(1'b1, `ECF_A_CTRL, 32'h9);
    bus(1'b1, `ECF_A_CMD, 32'h1);
    bus(1'b0, `ECF_A_STATUS, 32'h0);
    chk("standstill", started(q), 32'h1);
    bus(1'b1, `ECF_A_CMD, 32'h2);
  endtask : t_queue
  // Reset for two cycles, then the scenarios in turn
  initial begin
    nrst_i = 1'b0;
    hsel_i = 1'b0;
    hwrite_i = 1'b0;
    axis_fault_i = 1'b0;
    htrans_i = 2'h0;
    haddr_i = 32'h0;
    hwdata_i = 32'h0;
    repeat (2) @(posedge core_clk_i);
    nrst_i <= 1'b1;
    @(posedge core_clk_i);
    t_reset();
    setup();
    t_scale();
    t_repeat();
    t_styles();
    t_halt();
    t_fault();
    t_queue();
    end_sim();
  end
endmodule : tb
`default_nettype wire
